// file: logic/scm_pkg.sv
package scm_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NPORT = 8;
    localparam int NCHAN = 16;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int POS_W = 4;
    localparam int MODE_W = 3;
    localparam int UMAP_ENT_W = 8;
    localparam int UMAP_EN_BIT = 7;
    localparam int UMAP_REGS = 4;
    localparam int DIAG_W = 4;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IN_VALID = 8'h04;
    localparam logic [7:0] ADDR_OUT_VALID = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_DIAG = 8'h10;
    localparam logic [7:0] ADDR_UMAP0 = 8'h20;
    localparam logic [7:0] ADDR_UMAP3 = 8'h2C;
    localparam int CTRL_SRC_BIT = 3;

    // ------------------------------------------------------------
    // Modes and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_ONE = 3'h1;
    localparam logic [2:0] MODE_TWO = 3'h2;
    localparam logic [2:0] MODE_THREE = 3'h3;
    localparam logic [2:0] MODE_FOUR = 3'h4;
    localparam logic [2:0] MODE_FIVE = 3'h5;
    localparam logic [2:0] MODE_RST = MODE_TWO;
    localparam logic [15:0] VALID_RST = 16'hFFFF;
    localparam logic [31:0] UMAP_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Slot addressing on the process data link
    // ------------------------------------------------------------
    localparam logic [7:0] SC_SLOT = 8'h01;
    localparam logic [7:0] SC_SUBSLOT = 8'h01;
    localparam logic [7:0] PORT_SUB_FIRST = 8'h02;
    localparam logic [7:0] PORT_SUB_LAST = 8'h09;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [BYTE_W-1:0] first;
        logic [BYTE_W-1:0] second;
    } scm_link_word_t;

    typedef struct packed {
        logic en;
        logic [POS_W-1:0] pos;
    } scm_chan_pos_t;

    typedef struct packed {
        logic [MODE_W-1:0] mode;
        logic a_src_sc;
        logic [NCHAN-1:0] in_valid;
        logic [NCHAN-1:0] out_valid;
        logic [UMAP_REGS*32-1:0] umap;
    } scm_cfg_t;

    // Channel c: 0..7 channel A of port c+1, 8..15 channel B
    function automatic logic [2:0] chan_port(input int c);
        chan_port = 3'(c % NPORT);
    endfunction : chan_port

    function automatic logic chan_is_b(input int c);
        chan_is_b = (c >= NPORT);
    endfunction : chan_is_b
endpackage : scm_pkg

// file: logic/scm_pos_table.sv
`timescale 1ns/1ps
module scm_pos_table
    import scm_pkg::*;
(
    input wire logic [MODE_W-1:0] mode,
    input wire logic [UMAP_REGS*32-1:0] umap,
    output scm_chan_pos_t [NCHAN-1:0] pos_tab
);
    // ------------------------------------------------------------
    // Word bit position of every channel
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] p;
        logic b;
        logic [UMAP_ENT_W-1:0] ent;
        p = 3'h0;
        b = 1'b0;
        ent = '0;
        for (int c = 0; c < NCHAN; c++) begin
            p = chan_port(c);
            b = chan_is_b(c);
            ent = umap[c*UMAP_ENT_W +: UMAP_ENT_W];
            case (mode)
                MODE_ONE: begin
                    pos_tab[c] = '{1'b1, {p, b}};
                end
                MODE_TWO: begin
                    pos_tab[c] = '{1'b1, {~p[2], p[1:0], b}};
                end
                MODE_THREE: begin
                    pos_tab[c] = '{1'b1, {b, p}};
                end
                MODE_FOUR: begin
                    pos_tab[c] = '{1'b1, {~b, p}};
                end
                MODE_FIVE: begin
                    pos_tab[c] = '{ent[UMAP_EN_BIT],
                        ent[POS_W-1:0]};
                end
                default: begin
                    pos_tab[c] = '{1'b0, {POS_W{1'b0}}};
                end
            endcase
        end
    end
endmodule : scm_pos_table

// file: logic/scm_apb_regs.sv
`timescale 1ns/1ps
module scm_apb_regs
    import scm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [WORD_W-1:0] status_word,
    input wire logic [WORD_W-1:0] control_word,
    input wire logic [DIAG_W-1:0] diag_chan,
    output scm_cfg_t cfg
);
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_addr_chk
        $error("scm_apb_regs: ADDR_W outside 6 to 8");
    end

    scm_cfg_t cfg_ff, nxt_cfg;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pslverr_ff, nxt_pslverr;
    logic [7:0] a;
    logic setup;
    logic wr;

    // ------------------------------------------------------------
    // Decode and next values
    // ------------------------------------------------------------
    assign a = 8'(paddr);
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & ~pslverr_ff;

    function automatic logic is_umap(input logic [7:0] ad);
        is_umap = (ad >= ADDR_UMAP0) && (ad <= ADDR_UMAP3)
            && (ad[1:0] == 2'h0);
    endfunction : is_umap

    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (setup) begin
            nxt_pslverr = 1'b0;
            nxt_prdata = 32'h0000_0000;
            case (a)
                ADDR_CTRL: begin
                    nxt_prdata = {28'h0, cfg_ff.a_src_sc, cfg_ff.mode};
                end
                ADDR_IN_VALID: begin
                    nxt_prdata = {16'h0, cfg_ff.in_valid};
                end
                ADDR_OUT_VALID: begin
                    nxt_prdata = {16'h0, cfg_ff.out_valid};
                end
                ADDR_STATUS: begin
                    nxt_prdata = {control_word, status_word};
                end
                ADDR_DIAG: begin
                    nxt_prdata = {28'h0, diag_chan};
                end
                default: begin
                    if (is_umap(a)) begin
                        nxt_prdata = cfg_ff.umap[a[3:2]*32 +: 32];
                    end else begin
                        nxt_pslverr = 1'b1;
                    end
                end
            endcase
        end
        if (wr) begin
            case (a)
                ADDR_CTRL: begin
                    nxt_cfg.mode = pwdata[MODE_W-1:0];
                    nxt_cfg.a_src_sc = pwdata[CTRL_SRC_BIT];
                end
                ADDR_IN_VALID: begin
                    nxt_cfg.in_valid = pwdata[NCHAN-1:0];
                end
                ADDR_OUT_VALID: begin
                    nxt_cfg.out_valid = pwdata[NCHAN-1:0];
                end
                default: begin
                    if (is_umap(a)) begin
                        nxt_cfg.umap[a[3:2]*32 +: 32] = pwdata;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_ff <= '{MODE_RST, 1'b0, VALID_RST, VALID_RST,
                {UMAP_REGS{UMAP_RST}}};
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign cfg = cfg_ff;
    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = pslverr_ff & psel & penable;
endmodule : scm_apb_regs

// file: logic/scm_io_mapper.sv
`timescale 1ns/1ps
module scm_io_mapper
    import scm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lk_wr_en,
    input wire logic [7:0] lk_slot,
    input wire logic [7:0] lk_subslot,
    input wire scm_link_word_t lk_wr_data,
    output scm_link_word_t lk_status,
    output logic [NPORT-1:0][BYTE_W-1:0] port_in_byte,
    input wire logic [NPORT-1:0] chan_a_in,
    input wire logic [NPORT-1:0] chan_b_in,
    output logic [NPORT-1:0] chan_a_out,
    output logic [NPORT-1:0] chan_b_out,
    input wire logic [NPORT-1:0] diag_fault,
    output logic [DIAG_W-1:0] diag_chan
);
    scm_cfg_t cfg;
    scm_chan_pos_t [NCHAN-1:0] pos_tab;

    logic [WORD_W-1:0] ctrl_word_ff, nxt_ctrl_word;
    logic [NPORT-1:0] sub_out_bit_ff, nxt_sub_out_bit;
    scm_link_word_t status_ff, nxt_status;
    logic [NPORT-1:0][BYTE_W-1:0] in_byte_ff, nxt_in_byte;
    logic [NPORT-1:0] a_out_ff, nxt_a_out;
    logic [NPORT-1:0] b_out_ff, nxt_b_out;
    logic [DIAG_W-1:0] diag_ff, nxt_diag;
    logic [NCHAN-1:0] chan_val;
    logic [NCHAN-1:0] demap;
    logic sc_hit;
    logic port_hit;
    logic [7:0] port_idx;

    // ------------------------------------------------------------
    // Register file and position table
    // ------------------------------------------------------------
    scm_apb_regs #(
        .ADDR_W(8)
    ) u_regs (
        .clock(clock),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status_word(status_ff),
        .control_word(ctrl_word_ff),
        .diag_chan(diag_ff),
        .cfg(cfg)
    );

    scm_pos_table u_table (
        .mode(cfg.mode),
        .umap(cfg.umap),
        .pos_tab(pos_tab)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Lowest channel wins when two channels claim one word bit
    function automatic logic [WORD_W-1:0] pack_status(
        input scm_chan_pos_t [NCHAN-1:0] tab,
        input logic [NCHAN-1:0] val,
        input logic [NCHAN-1:0] vld
    );
        logic [WORD_W-1:0] w;
        logic [WORD_W-1:0] taken;
        w = '0;
        taken = '0;
        for (int c = 0; c < NCHAN; c++) begin
            if (tab[c].en && !taken[tab[c].pos]) begin
                taken[tab[c].pos] = 1'b1;
                w[tab[c].pos] = val[c] & vld[c];
            end
        end
        pack_status = w;
    endfunction : pack_status

    function automatic logic [DIAG_W-1:0] lowest_fault(
        input logic [NPORT-1:0] f
    );
        logic [DIAG_W-1:0] n;
        n = '0;
        for (int p = NPORT - 1; p >= 0; p--) begin
            if (f[p]) begin
                n = DIAG_W'(p + 1);
            end
        end
        lowest_fault = n;
    endfunction : lowest_fault

    // ------------------------------------------------------------
    // Link side: process data writes
    // ------------------------------------------------------------
    assign sc_hit = lk_wr_en && (lk_slot == SC_SLOT)
        && (lk_subslot == SC_SUBSLOT);
    assign port_hit = lk_wr_en && (lk_slot == SC_SLOT)
        && (lk_subslot >= PORT_SUB_FIRST) && (lk_subslot <= PORT_SUB_LAST);
    assign port_idx = lk_subslot - PORT_SUB_FIRST;

    // ------------------------------------------------------------
    // Mapping next values
    // ------------------------------------------------------------
    assign chan_val = {chan_b_in, chan_a_in};

    always_comb begin
        nxt_ctrl_word = ctrl_word_ff;
        nxt_sub_out_bit = sub_out_bit_ff;
        if (sc_hit) begin
            nxt_ctrl_word = {lk_wr_data.first, lk_wr_data.second};
        end
        if (port_hit) begin
            nxt_sub_out_bit[port_idx[2:0]] = lk_wr_data.first[0];
        end
        for (int c = 0; c < NCHAN; c++) begin
            demap[c] = pos_tab[c].en & cfg.out_valid[c]
                & ctrl_word_ff[pos_tab[c].pos];
        end
        nxt_status = pack_status(pos_tab, chan_val, cfg.in_valid);
        for (int p = 0; p < NPORT; p++) begin
            nxt_in_byte[p] = {7'h00,
                chan_a_in[p] & cfg.in_valid[p]};
        end
        nxt_b_out = demap[NCHAN-1:NPORT];
        if (cfg.a_src_sc) begin
            nxt_a_out = demap[NPORT-1:0];
        end else begin
            nxt_a_out = sub_out_bit_ff & cfg.out_valid[NPORT-1:0];
        end
        nxt_diag = lowest_fault(diag_fault);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_word_ff <= 16'h0000;
            sub_out_bit_ff <= 8'h00;
            status_ff <= 16'h0000;
            in_byte_ff <= '0;
            a_out_ff <= 8'h00;
            b_out_ff <= 8'h00;
            diag_ff <= 4'h0;
        end else begin
            ctrl_word_ff <= nxt_ctrl_word;
            sub_out_bit_ff <= nxt_sub_out_bit;
            status_ff <= nxt_status;
            in_byte_ff <= nxt_in_byte;
            a_out_ff <= nxt_a_out;
            b_out_ff <= nxt_b_out;
            diag_ff <= nxt_diag;
        end
    end

    assign lk_status = status_ff;
    assign port_in_byte = in_byte_ff;
    assign chan_a_out = a_out_ff;
    assign chan_b_out = b_out_ff;
    assign diag_chan = diag_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sc_word_write: assert property (
        @(posedge clock) disable iff (rst)
        sc_hit |=> ctrl_word_ff == {$past(lk_wr_data.first),
            $past(lk_wr_data.second)})
        else $error("control word not taken from link");

    a_port_bit_write: assert property (
        @(posedge clock) disable iff (rst)
        (lk_wr_en && lk_slot == SC_SLOT && lk_subslot == PORT_SUB_LAST)
        |=> sub_out_bit_ff[NPORT-1] == $past(lk_wr_data.first[0]))
        else $error("port sub-slot bit not taken");

    a_in_byte_copy: assert property (
        @(posedge clock) disable iff (rst)
        cfg.in_valid[0] |=> in_byte_ff[0] == {7'h00, $past(chan_a_in[0])})
        else $error("port input byte does not copy channel A");

    a_b_out_mode3: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.mode == MODE_THREE && cfg.out_valid[NCHAN-1])
        |=> b_out_ff[NPORT-1] == $past(ctrl_word_ff[WORD_W-1]))
        else $error("channel B output not from control word");

    a_a_src_sub: assert property (
        @(posedge clock) disable iff (rst)
        (!cfg.a_src_sc && cfg.out_valid[0])
        |=> a_out_ff[0] == $past(sub_out_bit_ff[0]))
        else $error("channel A output not from sub-slot bit");

    a_a_src_mode4: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.a_src_sc && cfg.mode == MODE_FOUR && cfg.out_valid[0])
        |=> a_out_ff[0] == $past(ctrl_word_ff[NPORT]))
        else $error("channel A output not from control word");

    a_mode1_status: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.mode == MODE_ONE && cfg.in_valid == VALID_RST)
        |=> status_ff.second[0] == $past(chan_a_in[0])
            && status_ff.first[7] == $past(chan_b_in[NPORT-1]))
        else $error("mode one placement wrong");

    a_mode2_status: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.mode == MODE_TWO && cfg.in_valid == VALID_RST)
        |=> status_ff.first[0] == $past(chan_a_in[0])
            && status_ff.second[1] == $past(chan_b_in[4]))
        else $error("mode two placement wrong");

    a_diag_chan: assert property (
        @(posedge clock) disable iff (rst)
        (diag_fault[2] && diag_fault[1:0] == 2'h0) |=> diag_ff == 4'h3)
        else $error("diagnostic channel number wrong");

    a_invalid_zero: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.mode == MODE_THREE && !cfg.in_valid[0])
        |=> status_ff.second[0] == 1'b0)
        else $error("invalid input position not zero");

    a_other_slot_skip: assert property (
        @(posedge clock) disable iff (rst)
        (!sc_hit && !port_hit)
        |=> ctrl_word_ff == $past(ctrl_word_ff)
            && sub_out_bit_ff == $past(sub_out_bit_ff))
        else $error("write outside slot 1 changed state");

    a_b_out_mode1: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.mode == MODE_ONE && cfg.out_valid[NPORT])
        |=> b_out_ff[0] == $past(ctrl_word_ff[1]))
        else $error("mode one channel B output wrong");

    a_mode3_status: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.mode == MODE_THREE && cfg.in_valid == VALID_RST)
        |=> status_ff.first[0] == $past(chan_b_in[0])
            && status_ff.second[7] == $past(chan_a_in[NPORT-1]))
        else $error("mode three placement wrong");

    a_mode4_status: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.mode == MODE_FOUR && cfg.in_valid == VALID_RST)
        |=> status_ff.first[7] == $past(chan_a_in[NPORT-1])
            && status_ff.second[0] == $past(chan_b_in[0]))
        else $error("mode four placement wrong");

    a_user_map_pos: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.mode == MODE_FIVE && cfg.umap[UMAP_EN_BIT] && cfg.in_valid[0])
        |=> status_ff[$past(cfg.umap[POS_W-1:0])] == $past(chan_a_in[0]))
        else $error("user map placement wrong");

    a_a_src_mode2: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.a_src_sc && cfg.mode == MODE_TWO && cfg.out_valid[0])
        |=> a_out_ff[0] == $past(ctrl_word_ff[NPORT]))
        else $error("channel A output took the sub-slot bit");

    a_unmapped_mode: assert property (
        @(posedge clock) disable iff (rst)
        (cfg.mode > MODE_FIVE)
        |=> status_ff == 16'h0000 && b_out_ff == 8'h00)
        else $error("unmapped mode drives a bit");

    a_out_invalid: assert property (
        @(posedge clock) disable iff (rst)
        !cfg.out_valid[NCHAN-1] |=> !b_out_ff[NPORT-1])
        else $error("invalid output position driven");

    a_diag_none: assert property (
        @(posedge clock) disable iff (rst)
        (diag_fault == 8'h00) |=> diag_ff == 4'h0)
        else $error("diagnostic channel without fault");
endmodule : scm_io_mapper

// file: verif/scm_link_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Cyclic process data controller model
// ------------------------------------------------------------
module scm_link_host
    import scm_pkg::*;
(
    input wire logic clock,
    output logic lk_wr_en,
    output logic [7:0] lk_slot,
    output logic [7:0] lk_subslot,
    output scm_link_word_t lk_wr_data
);
    initial begin
        lk_wr_en = 1'b0;
        lk_slot = 8'h00;
        lk_subslot = 8'h00;
        lk_wr_data = '0;
    end

    // One output write after gap+1 idle cycles
    task automatic send(input logic [7:0] sl, input logic [7:0] ss,
        input logic [15:0] w, input int gap);
        repeat (gap) @(posedge clock);
        @(posedge clock);
        lk_wr_en <= 1'b1;
        lk_slot <= sl;
        lk_subslot <= ss;
        lk_wr_data <= scm_link_word_t'(w);
        @(posedge clock);
        lk_wr_en <= 1'b0;
        lk_slot <= ~sl;
        lk_wr_data <= scm_link_word_t'(~w);
    endtask : send
endmodule : scm_link_host

// file: verif/status_control_io_mapper_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            error_cnt++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module status_control_io_mapper_bench
    import scm_pkg::*;
;
    logic clock;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lk_wr_en;
    logic [7:0] lk_slot;
    logic [7:0] lk_subslot;
    scm_link_word_t lk_wr_data;
    scm_link_word_t lk_status;
    logic [NPORT-1:0][BYTE_W-1:0] port_in_byte;
    logic [7:0] chan_a_in;
    logic [7:0] chan_b_in;
    logic [7:0] chan_a_out;
    logic [7:0] chan_b_out;
    logic [7:0] diag_fault;
    logic [3:0] diag_chan;
    int error_cnt;
    int total_checks;
    int md;
    int upos[16];
    logic src_m;
    logic [15:0] inv_m;
    logic [15:0] outv_m;
    logic [15:0] word_m;
    logic [15:0] in_m;
    logic [7:0] sub_m;
    logic [7:0] f_m;

    scm_io_mapper dut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .lk_wr_en, .lk_slot,
        .lk_subslot, .lk_wr_data, .lk_status, .port_in_byte, .chan_a_in,
        .chan_b_in, .chan_a_out, .chan_b_out, .diag_fault, .diag_chan);
    scm_link_host host (.clock, .lk_wr_en, .lk_slot, .lk_subslot,
        .lk_wr_data);

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic int pos_of(int c);
        int p = c % 8;
        int b = c / 8;
        case (md)
            1: return 2 * p + b;
            2: return (p < 4) ? 8 + 2 * p + b : 2 * (p - 4) + b;
            3: return (b == 1) ? 8 + p : p;
            4: return (b == 1) ? p : 8 + p;
            5: return upos[c];
            default: return -1;
        endcase
    endfunction : pos_of

    function automatic logic [15:0] exp_status();
        logic [15:0] st = 16'h0000;
        int q;
        for (int c = 0; c < 16; c++) begin
            q = pos_of(c);
            if (q >= 0 && inv_m[c] && in_m[c]) st[q] = 1'b1;
        end
        return st;
    endfunction : exp_status

    task automatic check_all();
        logic [15:0] st;
        logic [7:0] eb;
        logic ea;
        logic eo;
        logic [3:0] ed;
        int qa;
        int qb;
        @(negedge clock);
        st = exp_status();
        ed = 4'h0;
        `CHK(lk_status.first, st[15:8])
        `CHK(lk_status.second, st[7:0])
        for (int p = 7; p >= 0; p--) begin
            qa = pos_of(p);
            qb = pos_of(p + 8);
            eo = qb >= 0 && outv_m[p + 8] && word_m[qb];
            ea = src_m ? (qa >= 0 && word_m[qa]) : sub_m[p];
            ea = ea && outv_m[p];
            eb = {7'h00, in_m[p] & inv_m[p]};
            if (f_m[p]) ed = 4'(p + 1);
            `CHK(chan_b_out[p], eo)
            `CHK(chan_a_out[p], ea)
            `CHK(port_in_byte[p], eb)
        end
        `CHK(diag_chan, ed)
    endtask : check_all

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            error_cnt++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run_mode(input int m, input logic s);
        logic [31:0] r;
        logic [31:0] rd;
        logic [31:0] ew;
        logic err;
        apb(1'b1, ADDR_CTRL, {28'h0, s, 3'(m)}, rd, err);
        md = m;
        src_m = s;
        repeat (3) begin
            r = $urandom;
            @(posedge clock);
            chan_a_in <= r[7:0];
            chan_b_in <= r[15:8];
            diag_fault <= r[16] ? r[31:24] : 8'h00;
            in_m = r[15:0];
            f_m = r[16] ? r[31:24] : 8'h00;
            r = $urandom;
            word_m = r[15:0];
            host.send(SC_SLOT, SC_SUBSLOT, r[15:0], int'(r[17:16]));
            host.send(8'h02, SC_SUBSLOT, ~r[15:0], 0);
            host.send(SC_SLOT, 8'h0A, ~r[15:0], 0);
            for (int p = 0; p < 8; p++) begin
                r = $urandom;
                sub_m[p] = r[8];
                host.send(SC_SLOT, PORT_SUB_FIRST + 8'(p), r[15:0],
                    0);
            end
            repeat (3) @(posedge clock);
            check_all();
            apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
            ew = {word_m, exp_status()};
            `CHK(rd, ew)
        end
    endtask : run_mode

    task automatic give_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        logic [31:0] r;
        logic [31:0] rd;
        logic [31:0] um[4];
        logic err;
        int k;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        chan_a_in = 8'h00;
        chan_b_in = 8'h00;
        diag_fault = 8'h00;
        error_cnt = 0;
        total_checks = 0;
        md = 2;
        src_m = 1'b0;
        inv_m = 16'hFFFF;
        outv_m = 16'hFFFF;
        word_m = 16'h0000;
        in_m = 16'h0000;
        sub_m = 8'h00;
        f_m = 8'h00;
        void'($urandom(69125));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check_all();
        @(posedge clock);
        diag_fault <= 8'h0C;
        f_m = 8'h0C;
        @(posedge clock);
        check_all();
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
        `CHK(rd, 32'h0000_0002)
        apb(1'b0, 8'h14, 32'h0, rd, err);
        `CHK({err, rd}, 33'h1_0000_0000)
        run_mode(1, 1'b0);
        run_mode(2, 1'b1);
        run_mode(3, 1'b0);
        run_mode(4, 1'b1);
        k = $urandom % 16;
        for (int c = 0; c < 16; c++) begin
            r = $urandom;
            r[0] = r[0] | (c == 0);
            upos[c] = (r[1:0] != 2'h0) ? (c + k) % 16 : -1;
            um[c / 4][8 * (c % 4) +: 8] = {r[1:0] != 2'h0, 3'h0, 4'(c + k)};
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_UMAP0 + 8'(4 * i), um[i], rd, err);
        end
        run_mode(5, 1'b1);
        r = $urandom;
        inv_m = {r[15:1], 1'b0};
        outv_m = {1'b0, r[30:16]};
        apb(1'b1, ADDR_IN_VALID, {16'h0, inv_m}, rd, err);
        apb(1'b1, ADDR_OUT_VALID, {16'h0, outv_m}, rd, err);
        apb(1'b1, ADDR_STATUS, r, rd, err);
        apb(1'b0, ADDR_IN_VALID, 32'h0, rd, err);
        `CHK(rd, {16'h0, inv_m})
        run_mode(2, 1'b0);
        run_mode(5, 1'b0);
        run_mode(3, 1'b1);
        run_mode(6, 1'b1);
        give_verdict();
    end
endmodule : status_control_io_mapper_bench
